/* File: tb/ppc_pin_env.sv */
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_env #(parameter W = 8) (
	input wire logic [W-1:0] pinOut,
	input wire logic [W-1:0] pinOe,
	input wire logic [W-1:0] pinWeak,
	input wire logic [W-1:0] extLow,
	output logic [W-1:0] pinIn
);
	// released or weak-high lines rest at the board pull-up unless pulled low here
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (pinOe[i] && !pinWeak[i])
				pinIn[i] = pinOut[i];
			else
				pinIn[i] = !extLow[i];
		end
	end
endmodule
`default_nettype wire

/* File: tb/ppc_port_ctrl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ppc_port_ctrl_chk #(parameter W0 = 8, parameter W1 = 8, parameter W3 = 2) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic resetPinEnable,
	input wire logic extClockIn,
	input wire logic extCrystal,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [W1-1:0] port1In,
	input wire logic [W0-1:0] port0Out,
	input wire logic [W0-1:0] port0Oe,
	input wire logic [W0-1:0] port0Weak,
	input wire logic [W1-1:0] port1Out,
	input wire logic [W1-1:0] port1Oe,
	input wire logic [W1-1:0] port1Weak,
	input wire logic extResetReq_n,
	input wire logic [4:0] gpioPinCount
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence rdTaken;
		arvalid && arready;
	endsequence
	sequence pinHeldLow;
		(resetPinEnable && !port1In[5]) [*8];
	endsequence
	a_weak_needs_drive: assert property ((port0Weak & ~(port0Oe & port0Out)) == '0)
		else $error("weak high without drive");
	a_reset_pin_input: assert property (!port1Oe[5] && !port1Weak[5])
		else $error("reset-capable pin driven");
	a_bus_pins_od: assert property (port1Weak[3:2] == 2'h0 && (port1Oe[3:2] & port1Out[3:2]) == 2'h0)
		else $error("bus pin driven high");
	a_pin_count: assert property (arst_n |=> gpioPinCount == 5'd18 - 5'($past(resetPinEnable))
		- ($past(extCrystal) ? 5'd2 : 5'($past(extClockIn))))
		else $error("pin count wrong");
	a_reset_req_off: assert property (!resetPinEnable |=> extResetReq_n)
		else $error("reset request while disabled");
	a_reset_req_on: assert property (pinHeldLow |=> !extResetReq_n)
		else $error("reset request missing");
	a_bresp_once: assert property (bvalid && bready |=> !bvalid)
		else $error("write response repeated");
	a_read_answer: assert property (rdTaken |=> rvalid ##1 !rvalid)
		else $error("read answer late");
endmodule
bind ppc_port_ctrl ppc_port_ctrl_chk #(.W0(W0), .W1(W1), .W3(W3)) u_chk (.clock(clock),
	.arst_n(arst_n), .resetPinEnable(resetPinEnable), .extClockIn(extClockIn),
	.extCrystal(extCrystal), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
	.bvalid(bvalid), .bready(bready), .port1In(port1In), .port0Out(port0Out),
	.port0Oe(port0Oe), .port0Weak(port0Weak), .port1Out(port1Out), .port1Oe(port1Oe),
	.port1Weak(port1Weak), .extResetReq_n(extResetReq_n), .gpioPinCount(gpioPinCount));
`default_nettype wire

/* File: tb/tb_port_pin_config.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ppc_consts.vh"
module tb_port_pin_config;
	logic clock = 1'b0, arst_n = 1'b0, clkEn = 1'b1, resetPinEnable = 1'b0;
	logic extClockIn = 1'b0, extCrystal = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, ext0 = 8'h00, ext1 = 8'h00, lat;
	logic [7:0] port0In, port0Out, port0Oe, port0Weak, port1In, port1Out, port1Oe, port1Weak;
	logic [31:0] wdata = 32'h0, rdata, seed = 32'h8654;
	logic [1:0] bresp, rresp, port3In, port3Out, port3Oe, port3Weak;
	logic [3:0] wstrb = 4'hF;
	logic [4:0] gpioPinCount;
	logic extResetReq_n;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int n_fail = 0, tests_run = 0, i;
	ppc_port_ctrl dut (.clock(clock), .arst_n(arst_n), .clkEn(clkEn),
		.resetPinEnable(resetPinEnable), .extClockIn(extClockIn), .extCrystal(extCrystal),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .port0In(port0In), .port1In(port1In),
		.port3In(port3In), .port0Out(port0Out), .port0Oe(port0Oe), .port0Weak(port0Weak),
		.port1Out(port1Out), .port1Oe(port1Oe), .port1Weak(port1Weak), .port3Out(port3Out),
		.port3Oe(port3Oe), .port3Weak(port3Weak), .extResetReq_n(extResetReq_n),
		.gpioPinCount(gpioPinCount));
	ppc_pin_env #(.W(8)) env0 (.pinOut(port0Out), .pinOe(port0Oe), .pinWeak(port0Weak),
		.extLow(ext0), .pinIn(port0In));
	ppc_pin_env #(.W(8)) env1 (.pinOut(port1Out), .pinOe(port1Oe), .pinWeak(port1Weak),
		.extLow(ext1), .pinIn(port1In));
	assign port3In = 2'h3;
	always #20 clock = ~clock;
	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tally_and_finish();
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	// {out, oe, weak} for a type code and latch bit
	function automatic logic [2:0] drv(input logic [1:0] t, input logic l);
		case (t)
			2'h0: drv = {l, 1'b1, l};
			2'h1: drv = {l, 1'b1, 1'b0};
			2'h2: drv = {l, 2'b00};
			default: drv = {1'b0, !l, 1'b0};
		endcase
	endfunction
	task automatic chkPort(input bit p, input logic [7:0] c1, c2, l);
		logic [23:0] e;
		for (int b = 0; b < 8; b++)
			{e[16 + b], e[8 + b], e[b]} = drv({c1[b], c2[b]}, l[b]);
		chk("pins", {10'h0, e}, {10'h0, p ? {port1Out, port1Oe, port1Weak}
			: {port0Out, port0Oe, port0Weak}});
	endtask
	// e holds {resp, data}; answer is waited for under a bound
	task automatic xfer(input bit w, input logic [7:0] a, d, input logic [9:0] e);
		int k;
		@(posedge clock);
		if (w) begin
			bq.push_back(e[9:8]);
			awaddr <= a;
			wdata <= {24'h0, d};
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			rq.push_back({e[9:8], 24'h0, e[7:0]});
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		for (k = 0; k < 50; k++) begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (arready) arvalid <= 1'b0;
			if (bvalid) bready <= 1'b0;
			if (rvalid) rready <= 1'b0;
			if (bvalid || rvalid) break;
		end
		if (k == 50) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	always @(posedge clock) begin
		if (rvalid && rready) chk("read", rq.pop_front(), {rresp, rdata});
		if (bvalid && bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
	end
	task automatic rst();
		arst_n <= 1'b0;
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
	endtask
	initial begin
		rst();
		for (i = 0; i < 6; i++) xfer(0, 8'(4 * i), 0, {2'h0, (i % 3 == 2) ? 8'h00 : 8'hFF});
		xfer(0, `PPC_OFS_P0_DIS, 0, 10'h0);
		#1 chkPort(0, 8'hFF, 8'h00, 8'hFF);
		xfer(0, 8'h38, 0, {`PPC_AXI_SLVERR, 8'h00});
		xfer(1, 8'h38, 8'h5A, {`PPC_AXI_SLVERR, 8'h00});
		lat = rnd();
		xfer(1, `PPC_OFS_P0_OUT, lat, 10'h0);
		for (i = 0; i < 4; i++) begin
			xfer(1, `PPC_OFS_P0_CFG1, {8{i[1]}}, 10'h0);
			xfer(1, `PPC_OFS_P0_CFG2, {8{i[0]}}, 10'h0);
			@(posedge clock);
			#1 chkPort(0, {8{i[1]}}, {8{i[0]}}, lat);
		end
		xfer(1, `PPC_OFS_P0_CFG2, 8'h00, 10'h0);
		lat = rnd();
		ext0 <= lat;
		xfer(1, `PPC_OFS_P0_DIS, 8'hFF, 10'h0);
		xfer(0, `PPC_OFS_P0_DIS, 0, {2'h0, 8'h3E});
		xfer(0, `PPC_OFS_P0_IN, 0, {2'h0, ~lat & 8'hC1});
		ext0 <= ~lat;
		repeat (2) @(posedge clock);
		ext0 <= lat;
		repeat (8) @(posedge clock);
		xfer(0, `PPC_OFS_P0_IN, 0, {2'h0, ~lat & 8'hC1});
		lat = rnd();
		xfer(1, `PPC_OFS_P1_OUT, lat, 10'h0);
		xfer(1, `PPC_OFS_P1_CFG1, 8'h00, 10'h0);
		xfer(1, `PPC_OFS_P1_CFG2, 8'hFF, 10'h0);
		xfer(0, `PPC_OFS_P1_CFG1, 0, {2'h0, 8'h2C});
		xfer(0, `PPC_OFS_P1_CFG2, 0, {2'h0, 8'hDF});
		#1 chkPort(1, 8'h2C, 8'hDF, lat);
		xfer(1, `PPC_OFS_P3_OUT, 8'hFD, 10'h0);
		xfer(1, `PPC_OFS_P3_CFG1, 8'h00, 10'h0);
		xfer(1, `PPC_OFS_P3_CFG2, 8'hFF, 10'h0);
		xfer(0, `PPC_OFS_P3_OUT, 0, {2'h0, 8'h01});
		#1 chk("port3", {28'h0, 6'h1C}, {28'h0, port3Out, port3Oe, port3Weak});
		xfer(0, `PPC_OFS_P3_IN, 0, {2'h0, 8'h03});
		for (i = 0; i < 6; i++) begin
			resetPinEnable <= i[0];
			extClockIn <= (i / 2 == 1);
			extCrystal <= (i / 2 == 2);
			xfer(0, `PPC_OFS_STATUS, 0, {5'h1, 5'd18 - 5'(i % 2) - 5'(i / 2)});
		end
		ext1 <= 8'h20;
		repeat (10) @(posedge clock);
		xfer(0, `PPC_OFS_STATUS, 0, {5'h0, 5'd15});
		ext1 <= 8'h00;
		rst();
		xfer(0, `PPC_OFS_STATUS, 0, {5'h1, 5'd15});
		xfer(0, `PPC_OFS_P0_DIS, 0, 10'h0);
		#1 chkPort(0, 8'hFF, 8'h00, 8'hFF);
		tally_and_finish();
	end
endmodule
`default_nettype wire

/* File: verilog/ppc_consts.vh */
`ifndef PPC_CONSTS_VH
`define PPC_CONSTS_VH
// register byte offsets
`define PPC_OFS_P0_OUT 8'h00
`define PPC_OFS_P0_CFG1 8'h04
`define PPC_OFS_P0_CFG2 8'h08
`define PPC_OFS_P1_OUT 8'h0C
`define PPC_OFS_P1_CFG1 8'h10
`define PPC_OFS_P1_CFG2 8'h14
`define PPC_OFS_P3_OUT 8'h18
`define PPC_OFS_P3_CFG1 8'h1C
`define PPC_OFS_P3_CFG2 8'h20
`define PPC_OFS_P0_DIS 8'h24
`define PPC_OFS_P0_IN 8'h28
`define PPC_OFS_P1_IN 8'h2C
`define PPC_OFS_P3_IN 8'h30
`define PPC_OFS_STATUS 8'h34
// pin type code {cfg1,cfg2}
`define PPC_TYPE_QUASI 2'h0
`define PPC_TYPE_PUSH 2'h1
`define PPC_TYPE_INPUT 2'h2
`define PPC_TYPE_OPEN 2'h3
// reset values: every pin input-only
`define PPC_RST_CFG1 8'hFF
`define PPC_RST_CFG2 8'h00
`define PPC_RST_OUT 8'hFF
`define PPC_RST_DIS 8'h00
`define PPC_DIS_MASK 8'h3E
// fixed pins of port 1
`define PPC_BIT_BUS_CLOCK 2
`define PPC_BIT_BUS_DATA 3
`define PPC_BIT_RESET_PIN 5
// glitch filter: samples that must agree
`define PPC_FILT_LEN 3
`define PPC_AXI_OKAY 2'h0
`define PPC_AXI_SLVERR 2'h2
`endif

/* File: verilog/ppc_pin_driver.v */
`timescale 1ns/1ps
`default_nettype none
`include "ppc_consts.vh"
// maps pin type and latch to output and enable; weak flags a weak-high drive
module ppc_pin_driver (
	input wire [1:0] pinType,
	input wire latch,
	output reg pinOut,
	output reg pinOe,
	output reg pinWeak
);
	always @* begin
		pinOut = latch;
		pinOe = 1'b0;
		pinWeak = 1'b0;
		case (pinType)
			`PPC_TYPE_QUASI: begin
				pinOe = 1'b1;
				pinWeak = latch; // R5
			end
			`PPC_TYPE_PUSH: pinOe = 1'b1; // R8
			`PPC_TYPE_OPEN: begin
				pinOut = 1'b0;
				pinOe = ~latch; // R6
			end
			default: pinOe = 1'b0; // R7
		endcase
	end
endmodule
`default_nettype wire

/* File: verilog/ppc_pin_filter.v */
`timescale 1ns/1ps
`default_nettype none
`include "ppc_consts.vh"
// two-stage synchroniser then a run-length glitch filter
module ppc_pin_filter #(
	parameter LEN = `PPC_FILT_LEN
) (
	input wire clock,
	input wire arst_n,
	input wire clkEn,
	input wire pinIn,
	output reg level
);
	reg syncA_reg;
	reg syncB_reg;
	reg [LEN-1:0] hist_reg;
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			// start at the pull-up level so no false low follows reset
			syncA_reg <= 1'b1;
			syncB_reg <= 1'b1;
			hist_reg <= {LEN{1'b1}};
			level <= 1'b1;
		end else if (clkEn) begin
			syncA_reg <= pinIn;
			syncB_reg <= syncA_reg;
			hist_reg <= {hist_reg[LEN-2:0], syncB_reg};
			if (&hist_reg)
				level <= 1'b1;
			else if (~|hist_reg)
				level <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: verilog/ppc_port_ctrl.v */
// Overview of operation
// (R1) There are two 8-bit ports and one 2-bit port.
// (R2) Each configurable pin takes one of four types from two config registers per port.
// (R3) The reset-capable pin is always input and its type cannot be written.
// (R4) The two serial bus pins accept only input-only or open-drain.
// (R5) Weak-pull-up type drives a one weakly and a zero strongly.
// (R6) Open-drain type has no pull-up and pulls low only when the latch is zero.
// (R7) Input-only type disables all drivers.
// (R8) Push-pull type drives strongly high on one and low on zero.
// (R9) Every digital input is glitch filtered before use.
// (R10) Port 0 bits 1 to 5 have digital-input disable bits cleared by any reset.
// (R11) Software using an analog input selects input-only and disables the digital input.
// (R12) After power-up every pin is input-only.
// (R13) Up to 18 general pins, fewer with external reset, clock or crystal.
// (R14) With reset-pin enable set the reset-capable pin is an active-low reset input.
// (R15) Each pin has a writable latch; reads give filtered levels, disabled inputs as zero.
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_consts.vh"
module ppc_port_ctrl #(
	parameter W0 = 8,
	parameter W1 = 8,
	parameter W3 = 2
) (
	input wire clock,
	input wire arst_n,
	input wire clkEn,
	input wire resetPinEnable,
	input wire extClockIn,
	input wire extCrystal,
	input wire [7:0] awaddr,
	input wire awvalid,
	output reg awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	input wire [7:0] araddr,
	input wire arvalid,
	output reg arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	input wire [W0-1:0] port0In,
	input wire [W1-1:0] port1In,
	input wire [W3-1:0] port3In,
	output reg [W0-1:0] port0Out,
	output reg [W0-1:0] port0Oe,
	output reg [W0-1:0] port0Weak,
	output reg [W1-1:0] port1Out,
	output reg [W1-1:0] port1Oe,
	output reg [W1-1:0] port1Weak,
	output reg [W3-1:0] port3Out,
	output reg [W3-1:0] port3Oe,
	output reg [W3-1:0] port3Weak,
	output reg extResetReq_n,
	output reg [4:0] gpioPinCount
);
	localparam NP = W0 + W1 + W3; // R1
	// all three ports laid out flat
	reg [7:0] p0Out_reg, p0Cfg1_reg, p0Cfg2_reg, p0Dis_reg;
	reg [7:0] p1Out_reg, p1Cfg1_reg, p1Cfg2_reg;
	reg [7:0] p3Out_reg, p3Cfg1_reg, p3Cfg2_reg;
	wire [NP-1:0] pinsIn = {port3In, port1In, port0In};
	wire [NP-1:0] latchAll = {p3Out_reg[W3-1:0], p1Out_reg[W1-1:0], p0Out_reg[W0-1:0]};
	wire [NP-1:0] cfg1All = {p3Cfg1_reg[W3-1:0], p1Cfg1_reg[W1-1:0], p0Cfg1_reg[W0-1:0]};
	wire [NP-1:0] cfg2All = {p3Cfg2_reg[W3-1:0], p1Cfg2_reg[W1-1:0], p0Cfg2_reg[W0-1:0]};
	wire [NP-1:0] filtAll;
	wire [NP-1:0] drvOut, drvOe, drvWeak;
	genvar g;
	generate
		for (g = 0; g < NP; g = g + 1) begin : pinGen
			ppc_pin_filter #(.LEN(`PPC_FILT_LEN)) uFilt ( // R9
				.clock(clock),
				.arst_n(arst_n),
				.clkEn(clkEn),
				.pinIn(pinsIn[g]),
				.level(filtAll[g])
			);
			ppc_pin_driver uDrv ( // R2
				.pinType({cfg1All[g], cfg2All[g]}),
				.latch(latchAll[g]),
				.pinOut(drvOut[g]),
				.pinOe(drvOe[g]),
				.pinWeak(drvWeak[g])
			);
		end
	endgenerate

	// write-side sanitising of config values for restricted pins
	function [7:0] fixCfg1P1;
		input [7:0] v;
		begin
			fixCfg1P1 = v;
			fixCfg1P1[`PPC_BIT_BUS_CLOCK] = 1'b1; // R4
			fixCfg1P1[`PPC_BIT_BUS_DATA] = 1'b1; // R4
			fixCfg1P1[`PPC_BIT_RESET_PIN] = 1'b1; // R3
		end
	endfunction
	function [7:0] fixCfg2P1;
		input [7:0] v;
		begin
			fixCfg2P1 = v;
			fixCfg2P1[`PPC_BIT_RESET_PIN] = 1'b0; // R3
		end
	endfunction

	// AXI4-Lite write path: address and data taken in either order
	reg awHave_reg, wHave_reg;
	reg [7:0] awAddr_reg;
	reg [31:0] wData_reg;
	reg [3:0] wStrb_reg;
	wire doWrite = awHave_reg && wHave_reg && !bvalid;
	wire [7:0] wByte = wData_reg[7:0];
	wire wLane = wStrb_reg[0];
	reg wHit;
	always @* begin
		case (awAddr_reg)
			`PPC_OFS_P0_OUT, `PPC_OFS_P0_CFG1, `PPC_OFS_P0_CFG2,
			`PPC_OFS_P1_OUT, `PPC_OFS_P1_CFG1, `PPC_OFS_P1_CFG2,
			`PPC_OFS_P3_OUT, `PPC_OFS_P3_CFG1, `PPC_OFS_P3_CFG2,
			`PPC_OFS_P0_DIS, `PPC_OFS_P0_IN, `PPC_OFS_P1_IN,
			`PPC_OFS_P3_IN, `PPC_OFS_STATUS: wHit = 1'b1;
			default: wHit = 1'b0;
		endcase
	end

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			awHave_reg <= 1'b0;
			wHave_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg <= 32'h00000000;
			wStrb_reg <= 4'h0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `PPC_AXI_OKAY;
			p0Out_reg <= `PPC_RST_OUT;
			p1Out_reg <= `PPC_RST_OUT;
			p3Out_reg <= `PPC_RST_OUT;
			p0Cfg1_reg <= `PPC_RST_CFG1; // R12
			p0Cfg2_reg <= `PPC_RST_CFG2; // R12
			p1Cfg1_reg <= `PPC_RST_CFG1; // R12
			p1Cfg2_reg <= `PPC_RST_CFG2; // R12
			p3Cfg1_reg <= `PPC_RST_CFG1; // R12
			p3Cfg2_reg <= `PPC_RST_CFG2; // R12
			p0Dis_reg <= `PPC_RST_DIS; // R10
		end else if (clkEn) begin
			awready <= !awHave_reg && awvalid && !awready;
			wready <= !wHave_reg && wvalid && !wready;
			if (awvalid && awready) begin
				awHave_reg <= 1'b1;
				awAddr_reg <= awaddr;
			end
			if (wvalid && wready) begin
				wHave_reg <= 1'b1;
				wData_reg <= wdata;
				wStrb_reg <= wstrb;
			end
			if (bvalid && bready)
				bvalid <= 1'b0;
			if (doWrite) begin
				awHave_reg <= 1'b0;
				wHave_reg <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wHit ? `PPC_AXI_OKAY : `PPC_AXI_SLVERR;
				if (wLane) begin
					case (awAddr_reg)
						`PPC_OFS_P0_OUT: p0Out_reg <= wByte; // R15
						`PPC_OFS_P0_CFG1: p0Cfg1_reg <= wByte;
						`PPC_OFS_P0_CFG2: p0Cfg2_reg <= wByte;
						`PPC_OFS_P1_OUT: p1Out_reg <= wByte; // R15
						`PPC_OFS_P1_CFG1: p1Cfg1_reg <= fixCfg1P1(wByte);
						`PPC_OFS_P1_CFG2: p1Cfg2_reg <= fixCfg2P1(wByte);
						`PPC_OFS_P3_OUT: p3Out_reg <= wByte;
						`PPC_OFS_P3_CFG1: p3Cfg1_reg <= wByte;
						`PPC_OFS_P3_CFG2: p3Cfg2_reg <= wByte;
						`PPC_OFS_P0_DIS: p0Dis_reg <= wByte & `PPC_DIS_MASK; // R10
						default: p0Dis_reg <= p0Dis_reg;
					endcase
				end
			end
		end
	end

	// read values; port 0 inputs gated by the disable bits
	wire [7:0] p0InMasked = {{(8-W0){1'b0}}, filtAll[W0-1:0] & ~p0Dis_reg[W0-1:0]}; // R15
	wire [7:0] p1InVal = {{(8-W1){1'b0}}, filtAll[W0+W1-1:W0]};
	wire [7:0] p3InVal = {{(8-W3){1'b0}}, filtAll[NP-1:W0+W1]};
	reg [7:0] rByte;
	reg rHit;
	always @* begin
		rHit = 1'b1;
		case (araddr)
			`PPC_OFS_P0_OUT: rByte = p0Out_reg;
			`PPC_OFS_P0_CFG1: rByte = p0Cfg1_reg;
			`PPC_OFS_P0_CFG2: rByte = p0Cfg2_reg;
			`PPC_OFS_P1_OUT: rByte = p1Out_reg;
			`PPC_OFS_P1_CFG1: rByte = p1Cfg1_reg;
			`PPC_OFS_P1_CFG2: rByte = p1Cfg2_reg;
			`PPC_OFS_P3_OUT: rByte = p3Out_reg & {{(8-W3){1'b0}}, {W3{1'b1}}};
			`PPC_OFS_P3_CFG1: rByte = p3Cfg1_reg & {{(8-W3){1'b0}}, {W3{1'b1}}};
			`PPC_OFS_P3_CFG2: rByte = p3Cfg2_reg & {{(8-W3){1'b0}}, {W3{1'b1}}};
			`PPC_OFS_P0_DIS: rByte = p0Dis_reg;
			`PPC_OFS_P0_IN: rByte = p0InMasked;
			`PPC_OFS_P1_IN: rByte = p1InVal;
			`PPC_OFS_P3_IN: rByte = p3InVal;
			`PPC_OFS_STATUS: rByte = {2'h0, extResetReq_n, gpioPinCount};
			default: begin
				rByte = 8'h00;
				rHit = 1'b0;
			end
		endcase
	end

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `PPC_AXI_OKAY;
		end else if (clkEn) begin
			arready <= arvalid && !arready && !rvalid;
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata <= {24'h000000, rByte};
				rresp <= rHit ? `PPC_AXI_OKAY : `PPC_AXI_SLVERR;
			end else if (rvalid && rready)
				rvalid <= 1'b0;
		end
	end

	// pin outputs, registered
	wire rstPinLevel = filtAll[W0 + `PPC_BIT_RESET_PIN];
	reg [4:0] pinCountNext;
	always @* begin
		pinCountNext = 5'd18; // R13
		if (resetPinEnable)
			pinCountNext = pinCountNext - 5'd1; // R13
		if (extCrystal)
			pinCountNext = pinCountNext - 5'd2; // R13
		else if (extClockIn)
			pinCountNext = pinCountNext - 5'd1; // R13
	end
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			port0Out <= {W0{1'b0}};
			port0Oe <= {W0{1'b0}};
			port0Weak <= {W0{1'b0}};
			port1Out <= {W1{1'b0}};
			port1Oe <= {W1{1'b0}};
			port1Weak <= {W1{1'b0}};
			port3Out <= {W3{1'b0}};
			port3Oe <= {W3{1'b0}};
			port3Weak <= {W3{1'b0}};
			extResetReq_n <= 1'b1;
			gpioPinCount <= 5'd0;
		end else if (clkEn) begin
			port0Out <= drvOut[W0-1:0];
			port0Oe <= drvOe[W0-1:0];
			port0Weak <= drvWeak[W0-1:0];
			port1Out <= drvOut[W0+W1-1:W0];
			port1Oe <= drvOe[W0+W1-1:W0];
			port1Weak <= drvWeak[W0+W1-1:W0];
			port3Out <= drvOut[NP-1:W0+W1];
			port3Oe <= drvOe[NP-1:W0+W1];
			port3Weak <= drvWeak[NP-1:W0+W1];
			extResetReq_n <= !(resetPinEnable && !rstPinLevel); // R14
			gpioPinCount <= pinCountNext;
		end
	end
endmodule
`default_nettype wire
